// ### rtl/tcr_pkg.sv
// constants, types and layout of the transmit control register block
// How it works
// - transmit start loads descriptor bits 15..12
// - transmit end sets status bits 10..0 except 8 and 4
// - status plus collision count written to descriptor
// - writeback done clears bits 9 and 5
// - next start clears 10,7,6,3..0; sets 8
// - hardware reset forces bits 8 and 1
// - software reset leaves the register alone
// - 15..12 read/write, 10..0 read-only, 11,4 zero
// - fixed field positions, sent_ok at bit 0
// - flagged descriptor fetch raises programmed interrupt flag while register bit 15 is clear
// - bit 14 picks late collision timer start
// - bit 13 set omits the 4-byte checksum
// - bit 12 set disables long deferral timer
// - 3.2 ms deferral aborts, sets bit 10
// - sixteenth collision aborts, sets bit 6
// - carrier_absent set at transmit start, cleared on carrier
package tcr_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] TC_IDX = 6'h03;
	localparam logic [5:0] IRQ_STAT_IDX = 6'h04;
	localparam logic [5:0] IRQ_MASK_IDX = 6'h05;
	// transmit_control field positions
	localparam int B_PIRQ = 15;
	localparam int B_OWCSEL = 14;
	localparam int B_FCSOMIT = 13;
	localparam int B_DEFOFF = 12;
	localparam int B_EXD = 10;
	localparam int B_DEF = 9;
	localparam int B_CARRIER_ABSENT = 8;
	localparam int B_CARRIER_DROPPED = 7;
	localparam int B_EXC = 6;
	localparam int B_OWC = 5;
	localparam int B_PMB = 3;
	localparam int B_FU = 2;
	localparam int B_BCM = 1;
	localparam int B_PTX = 0;
	localparam logic [15:0] TC_RESET = 16'h0102;
	localparam logic [15:0] TC_RW_MASK = 16'hF000;
	localparam logic [15:0] TC_STATUS_MASK = 16'h07EF;
	localparam logic [15:0] TC_CLR_AT_START = 16'h04CF;
	localparam logic [15:0] TC_SET_AT_START = 16'h0100;
	localparam logic [15:0] TC_CLR_AFTER_WB = 16'h0220;
	// interrupt status / mask layout
	localparam int IRQ_W = 3;
	localparam int IRQ_PROGRAMMED_IRQ_FLAG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_ABORT = 2;
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int DEFER_TIME_NS = 3200000;
	localparam int DEFER_CYC = DEFER_TIME_NS / CLK_PERIOD_NS;
	localparam int SLOT_TIME_NS = 51200;
	localparam int SLOT_CYC = SLOT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [4:0] LAST_COLL = 5'h0F;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		TCR_IDLE = 3'h1,
		TCR_SEND = 3'h2,
		TCR_WB = 3'h4
	} tcr_state_t;

	typedef struct packed
	{
		logic packet_irq_request;
		logic late_collision_timer_select;
		logic checksum_omit;
		logic long_defer_timer_off;
	} tcr_cfg_t;

	typedef struct packed
	{
		logic preamble_start;
		logic sfd_sent;
		logic collision;
		logic monitored_bad_frame;
		logic tx_buffer_starved;
		logic length_mismatch;
		logic sent_ok;
		logic tx_end;
	} tcr_tx_evt_t;
endpackage

// ### rtl/tcr_top.sv
// transmit control/status register with descriptor load, status writeback and interrupts
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module tcr_top
#(
	parameter int DEFER_CYC = tcr_pkg::DEFER_CYC,
	parameter int SLOT_CYC = tcr_pkg::SLOT_CYC,
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk_i, // controller clock
	input wire logic rst_n_i, // hardware reset, sync, active low
	input wire logic ce_i, // clock enable, freezes all state
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic desc_fetch_i, // pulse: descriptor fetched
	input wire logic tx_start_i, // pulse: transmission begins
	input wire logic [15:0] descriptor_config_word_i, // config word of current descriptor
	input wire tcr_pkg::tcr_tx_evt_t tx_evt_i, // transmit engine event pulses
	input wire logic deferring_i, // level: engine is deferring
	input wire logic carrier_sense_i, // carrier sense pin, asynchronous
	output tcr_pkg::tcr_cfg_t cfg_o, // live configuration bits 15..12
	output logic fcs_append_o, // append 4-byte checksum
	output logic late_timer_start_o, // pulse: late collision timer starts
	output logic tx_abort_o, // pulse: abort transmission
	output logic packet_irq_set_o, // pulse: programmed interrupt set request
	output logic desc_status_valid_o, // descriptor status word offered
	output logic [15:0] descriptor_status_word_o, // status word for memory
	input wire logic desc_status_ready_i, // memory took the status word
	output logic irq_o // level interrupt
);
	localparam int DEFER_W = $clog2(DEFER_CYC + 1);
	localparam int SLOT_W = $clog2(SLOT_CYC + 1);

	////////////////////////////////////////////////////////////////////////////
	// state
	tcr_pkg::tcr_state_t state;
	tcr_pkg::tcr_state_t next_state;
	logic [15:0] tc;
	logic [15:0] next_tc;
	logic [15:0] pend;
	logic [15:0] next_pend;
	logic [4:0] coll_cnt;
	logic [DEFER_W-1:0] defer_cnt;
	logic [SLOT_W-1:0] slot_cnt;
	logic slot_run;
	logic crs_meta;
	logic crs_sync;
	logic crs_win;
	logic [tcr_pkg::IRQ_W-1:0] irq_stat;
	logic [tcr_pkg::IRQ_W-1:0] irq_mask;
	logic [tcr_pkg::IRQ_W-1:0] next_irq_stat;
	// bus slave holding registers
	logic [ADDR_W-1:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;

	////////////////////////////////////////////////////////////////////////////
	// decode
	wire in_idle = (state == tcr_pkg::TCR_IDLE);
	wire in_send = (state == tcr_pkg::TCR_SEND);
	wire in_wb = (state == tcr_pkg::TCR_WB);
	wire start = in_idle & tx_start_i;
	wire coll = in_send & tx_evt_i.collision;
	wire coll16 = coll & (coll_cnt == tcr_pkg::LAST_COLL);
	wire defer_on = in_send & deferring_i & ~tc[tcr_pkg::B_DEFOFF];
	wire defer_hit = defer_on & (defer_cnt == DEFER_W'(DEFER_CYC - 1));
	wire abort_now = defer_hit | coll16;
	wire finish = in_send & (tx_evt_i.tx_end | abort_now);
	wire wb_done = in_wb & desc_status_ready_i;
	wire slot_done = (slot_cnt == SLOT_W'(SLOT_CYC));
	// timer start point chosen by the select bit
	wire slot_go = in_send & (tc[tcr_pkg::B_OWCSEL] ? tx_evt_i.preamble_start : tx_evt_i.sfd_sent);
	// flag only when the register bit is clear, so alternating descriptors re-arm it
	wire pirq = desc_fetch_i & descriptor_config_word_i[tcr_pkg::B_PIRQ] & ~tc[tcr_pkg::B_PIRQ];
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_full & w_full & ~s_axi_bvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [5:0] wr_idx = aw_addr[7:2];
	wire [5:0] rd_idx = s_axi_araddr[7:2];
	wire wr_tc = do_write & (wr_idx == tcr_pkg::TC_IDX) & w_strb[1];
	wire wr_is = do_write & (wr_idx == tcr_pkg::IRQ_STAT_IDX) & w_strb[0];
	wire wr_im = do_write & (wr_idx == tcr_pkg::IRQ_MASK_IDX) & w_strb[0];
	wire wr_hit = (wr_idx == tcr_pkg::TC_IDX) | (wr_idx == tcr_pkg::IRQ_STAT_IDX) | (wr_idx == tcr_pkg::IRQ_MASK_IDX);
	wire rd_hit = (rd_idx == tcr_pkg::TC_IDX) | (rd_idx == tcr_pkg::IRQ_STAT_IDX) | (rd_idx == tcr_pkg::IRQ_MASK_IDX);
	wire [31:0] rd_mux = (rd_idx == tcr_pkg::TC_IDX) ? {16'h0000, tc & (tcr_pkg::TC_RW_MASK | tcr_pkg::TC_STATUS_MASK)} :
		(rd_idx == tcr_pkg::IRQ_STAT_IDX) ? {29'h0000000, irq_stat} :
		(rd_idx == tcr_pkg::IRQ_MASK_IDX) ? {29'h0000000, irq_mask} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// outcome of the current transmission, collected until it ends
	always_comb
	begin
		next_pend = pend;
		if (start)
			next_pend = 16'h0000;
		if (coll)
			next_pend[tcr_pkg::B_DEF] = 1'b0;
		// deferring on the first attempt counts whether or not the long timer runs
		if (in_send && deferring_i && coll_cnt == 5'h00 && !coll)
			next_pend[tcr_pkg::B_DEF] = 1'b1;
		if (defer_hit)
			next_pend[tcr_pkg::B_EXD] = 1'b1;
		if (crs_win && !crs_sync)
			next_pend[tcr_pkg::B_CARRIER_DROPPED] = 1'b1;
		if (coll16)
			next_pend[tcr_pkg::B_EXC] = 1'b1;
		if (coll && slot_done)
			next_pend[tcr_pkg::B_OWC] = 1'b1;
		if (in_send && tx_evt_i.monitored_bad_frame)
			next_pend[tcr_pkg::B_PMB] = 1'b1;
		if (in_send && tx_evt_i.tx_buffer_starved)
			next_pend[tcr_pkg::B_FU] = 1'b1;
		if (in_send && tx_evt_i.length_mismatch)
			next_pend[tcr_pkg::B_BCM] = 1'b1;
		if (in_send && tx_evt_i.sent_ok)
			next_pend[tcr_pkg::B_PTX] = 1'b1;
	end

	// register update; a transmit start overrides a same-cycle software write
	always_comb
	begin
		next_tc = tc;
		if (wr_tc)
			next_tc = (tc & ~tcr_pkg::TC_RW_MASK) | (w_data[15:0] & tcr_pkg::TC_RW_MASK);
		if (wb_done)
			next_tc = next_tc & ~tcr_pkg::TC_CLR_AFTER_WB;
		if (start)
		begin
			next_tc = (next_tc & ~tcr_pkg::TC_CLR_AT_START) | tcr_pkg::TC_SET_AT_START;
			next_tc[15:12] = descriptor_config_word_i[15:12];
		end
		if (in_send && crs_sync)
			next_tc[tcr_pkg::B_CARRIER_ABSENT] = 1'b0;
		if (finish)
			next_tc = next_tc | (next_pend & tcr_pkg::TC_STATUS_MASK & ~tcr_pkg::TC_SET_AT_START);
	end

	always_comb
	begin
		next_irq_stat = irq_stat;
		if (wr_is)
			next_irq_stat = irq_stat & ~w_data[tcr_pkg::IRQ_W-1:0];
		// sets win over a same-cycle clear
		if (pirq)
			next_irq_stat[tcr_pkg::IRQ_PROGRAMMED_IRQ_FLAG] = 1'b1;
		if (wb_done)
			next_irq_stat[tcr_pkg::IRQ_DONE] = 1'b1;
		if (abort_now)
			next_irq_stat[tcr_pkg::IRQ_ABORT] = 1'b1;
	end

	always_comb
	begin
		case (state)
			tcr_pkg::TCR_IDLE: next_state = tx_start_i ? tcr_pkg::TCR_SEND : tcr_pkg::TCR_IDLE;
			tcr_pkg::TCR_SEND: next_state = finish ? tcr_pkg::TCR_WB : tcr_pkg::TCR_SEND;
			tcr_pkg::TCR_WB: next_state = desc_status_ready_i ? tcr_pkg::TCR_IDLE : tcr_pkg::TCR_WB;
			default: next_state = tcr_pkg::TCR_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit side flops; only the hardware reset touches the register
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= tcr_pkg::TCR_IDLE;
			tc <= tcr_pkg::TC_RESET;
			pend <= 16'h0000;
			coll_cnt <= 5'h00;
			defer_cnt <= '0;
			slot_cnt <= '0;
			slot_run <= 1'b0;
			crs_win <= 1'b0;
		end
		else if (ce_i)
		begin
			state <= next_state;
			tc <= next_tc;
			pend <= next_pend;
			coll_cnt <= start ? 5'h00 : (coll ? coll_cnt + 5'h01 : coll_cnt);
			defer_cnt <= defer_on ? defer_cnt + DEFER_W'(1) : '0;
			slot_run <= ~start & ~finish & (slot_run | slot_go);
			if (start || slot_go)
				slot_cnt <= '0;
			else if (slot_run && !slot_done)
				slot_cnt <= slot_cnt + SLOT_W'(1);
			crs_win <= ~start & ~finish & (crs_win | (in_send & tx_evt_i.sfd_sent));
		end
	end

	// carrier sense comes from a pin: two flops before use
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			crs_meta <= 1'b0;
			crs_sync <= 1'b0;
		end
		else if (ce_i)
		begin
			crs_meta <= carrier_sense_i;
			crs_sync <= crs_meta;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			fcs_append_o <= 1'b1;
			late_timer_start_o <= 1'b0;
			tx_abort_o <= 1'b0;
			packet_irq_set_o <= 1'b0;
			desc_status_valid_o <= 1'b0;
			descriptor_status_word_o <= 16'h0000;
			irq_stat <= '0;
			irq_mask <= '0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			fcs_append_o <= ~next_tc[tcr_pkg::B_FCSOMIT];
			late_timer_start_o <= slot_go;
			tx_abort_o <= abort_now;
			packet_irq_set_o <= pirq;
			if (finish)
			begin
				desc_status_valid_o <= 1'b1;
				// collision count in the top five bits beside the status bits
				descriptor_status_word_o <= {coll ? coll_cnt + 5'h01 : coll_cnt, next_tc[10:0]};
			end
			else if (wb_done)
				desc_status_valid_o <= 1'b0;
			irq_stat <= next_irq_stat;
			if (wr_im)
				irq_mask <= w_data[tcr_pkg::IRQ_W-1:0];
			irq_o <= |(next_irq_stat & (wr_im ? w_data[tcr_pkg::IRQ_W-1:0] : irq_mask));
		end
	end
	assign cfg_o = tc[15:12];

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: one write and one read in flight
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tcr_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= tcr_pkg::RESP_OKAY;
			aw_addr <= '0;
			aw_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			w_full <= 1'b0;
		end
		else if (ce_i)
		begin
			if (aw_take)
			begin
				aw_addr <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (ar_take)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // tcr_top

// ### verif/tcr_top_chk.sv
// port assertions for the transmit control register block
`timescale 1ns/10ps
module tcr_top_chk
(
	input wire logic ref_clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic ce_i, // enable
	input wire logic desc_fetch_i, // fetch
	input wire logic tx_start_i, // start
	input wire logic [15:0] descriptor_config_word_i, // config
	input wire tcr_pkg::tcr_tx_evt_t tx_evt_i, // events
	input wire logic deferring_i, // deferring
	input wire logic s_axi_bvalid, // write answer
	input wire tcr_pkg::tcr_cfg_t cfg_o, // config bits
	input wire logic fcs_append_o, // checksum on
	input wire logic late_timer_start_o, // timer start
	input wire logic tx_abort_o, // abort
	input wire logic packet_irq_set_o, // irq set
	input wire logic desc_status_valid_o, // word valid
	input wire logic [15:0] descriptor_status_word_o, // word
	input wire logic desc_status_ready_i // word taken
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i || !ce_i);
	pirq_raise_a: assert property (desc_fetch_i && descriptor_config_word_i[15] && !cfg_o.packet_irq_request
		|=> packet_irq_set_o) else $error("irq set request missing");
	pirq_cause_a: assert property (packet_irq_set_o
		|-> $past(desc_fetch_i && descriptor_config_word_i[15])) else $error("irq set without cause");
	pirq_single_a: assert property (packet_irq_set_o |=> !packet_irq_set_o) else $error("irq set too long");
	fcs_level_a: assert property ($stable(cfg_o.checksum_omit)
		|-> fcs_append_o == !cfg_o.checksum_omit) else $error("checksum append wrong");
	late_start_a: assert property (late_timer_start_o
		|-> $past(cfg_o.late_collision_timer_select ? tx_evt_i.preamble_start : tx_evt_i.sfd_sent))
		else $error("late timer started at wrong point");
	defer_off_a: assert property (desc_status_valid_o && cfg_o.long_defer_timer_off
		|-> !descriptor_status_word_o[10]) else $error("deferral abort while timer off");
	word_hold_a: assert property (desc_status_valid_o && !desc_status_ready_i
		|=> desc_status_valid_o && $stable(descriptor_status_word_o)) else $error("status word dropped");
	abort_cause_a: assert property (tx_abort_o |-> $past(tx_evt_i.collision || deferring_i))
		else $error("abort without cause");
	cfg_load_a: assert property ($changed(cfg_o) |-> $past(tx_start_i) || $rose(s_axi_bvalid))
		else $error("config bits changed without cause");
endmodule // tcr_top_chk
bind tcr_top tcr_top_chk u_chk (.ref_clk_i, .rst_n_i, .ce_i, .desc_fetch_i, .tx_start_i, .descriptor_config_word_i,
	.tx_evt_i, .deferring_i, .s_axi_bvalid, .cfg_o, .fcs_append_o, .late_timer_start_o, .tx_abort_o,
	.packet_irq_set_o, .desc_status_valid_o, .descriptor_status_word_o, .desc_status_ready_i);

// ### verif/tcr_desc_mem.sv
// descriptor memory model: presents config words, stores status words
`timescale 1ns/10ps
module tcr_desc_mem
(
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic sel_i, // config word being read
	input wire logic [15:0] word_i, // stored config word
	input wire logic [3:0] stall_i, // wait before taking status
	input wire logic valid_i, // status offered
	input wire logic [15:0] status_i, // status word
	output logic ready_o, // status taken
	output logic [15:0] cfg_o, // config word lines
	output logic [15:0] last_o, // last status stored
	output int count_o // status words stored
);
	logic [3:0] wait_q;
	// lines not being read show the inverse so stale data cannot pass
	assign cfg_o = sel_i ? word_i : ~word_i;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !valid_i || ready_o)
		begin
			wait_q <= 4'h0;
			ready_o <= 1'b0;
		end
		else if (wait_q >= stall_i)
			ready_o <= 1'b1;
		else
			wait_q <= wait_q + 4'h1;
		if (valid_i && ready_o)
		begin
			last_o <= status_i;
			count_o <= count_o + 1;
		end
	end
endmodule // tcr_desc_mem

// ### verif/tb_transmit_control_status_register.sv
// self-checking bench for the transmit control register block
`timescale 1ns/10ps
module tb_transmit_control_status_register;
	logic ref_clk_i = 0, rst_n_i = 0, ce_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, desc_fetch_i = 0, tx_start_i = 0, deferring_i = 0;
	logic carrier_sense_i = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic fcs_append_o, late_timer_start_o, tx_abort_o, packet_irq_set_o, desc_status_valid_o;
	logic desc_status_ready_i, irq_o, msel = 0, pirq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h622D, rd, r;
	logic [3:0] s_axi_wstrb = 4'hF, stall = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [15:0] descriptor_config_word_i, descriptor_status_word_o, mword = 16'h0, mlast, cf, st;
	tcr_pkg::tcr_tx_evt_t tx_evt_i = 8'h00;
	tcr_pkg::tcr_cfg_t cfg_o;
	int bad_count = 0, checks = 0, mcount, n, m0;
	always #2 ref_clk_i = ~ref_clk_i;
	tcr_top #(.DEFER_CYC(40), .SLOT_CYC(20)) uut (.ref_clk_i, .rst_n_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .desc_fetch_i, .tx_start_i, .descriptor_config_word_i, .tx_evt_i, .deferring_i,
		.carrier_sense_i, .cfg_o, .fcs_append_o, .late_timer_start_o, .tx_abort_o, .packet_irq_set_o,
		.desc_status_valid_o, .descriptor_status_word_o, .desc_status_ready_i, .irq_o);
	tcr_desc_mem mem (.clk_i(ref_clk_i), .rst_n_i, .sel_i(msel), .word_i(mword), .stall_i(stall),
		.valid_i(desc_status_valid_o), .status_i(descriptor_status_word_o), .ready_o(desc_status_ready_i),
		.cfg_o(descriptor_config_word_i), .last_o(mlast), .count_o(mcount));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 200)
		begin
			bad_count++;
			$display("Error at %0t: wait ran out", $time);
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 200 && !(s_axi_bvalid && s_axi_bready); n++)
		begin
			@(posedge ref_clk_i);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		tmo(n);
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge ref_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 200 && !(s_axi_rvalid && s_axi_rready); n++)
		begin
			@(posedge ref_clk_i);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		tmo(n);
	endtask
	task automatic ev(input int b);
		@(posedge ref_clk_i);
		tx_evt_i <= tcr_pkg::tcr_tx_evt_t'(8'h01 << b);
		@(posedge ref_clk_i);
		tx_evt_i <= 8'h00;
	endtask
	// fetch then start; the set request is sampled one cycle after the fetch
	task automatic send(input logic [15:0] c);
		@(posedge ref_clk_i);
		mword <= c;
		msel <= 1;
		desc_fetch_i <= 1;
		@(posedge ref_clk_i);
		desc_fetch_i <= 0;
		msel <= 0;
		@(posedge ref_clk_i);
		pirq = packet_irq_set_o;
		msel <= 1;
		tx_start_i <= 1;
		@(posedge ref_clk_i);
		tx_start_i <= 0;
		msel <= 0;
		m0 = mcount;
	endtask
	task automatic fin();
		for (n = 0; n < 200 && mcount == m0; n++)
			@(posedge ref_clk_i);
		tmo(n);
	endtask
	initial
	begin
		repeat (100000) @(posedge ref_clk_i);
		tmo(200);
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1;
		rdr(8'h0C);
		chk(rd, 32'h0102);
		rdr(8'h3C);
		chk(32'(rr), 32'h2);
		wr(8'h0C, 32'hFFFFFFFF);
		rdr(8'h0C);
		chk(rd, 32'hF102);
		wr(8'h0C, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			r = rnd();
			// programmed interrupt on alternate descriptors only
			cf = (r[15:0] & 16'h7000) | (i % 2 ? 16'h8000 : 16'h0000);
			stall <= r[7:5];
			carrier_sense_i <= (i != 2);
			send(cf);
			chk(32'(pirq), 32'(i % 2));
			ev(7);
			chk(32'(cfg_o), 32'(cf[15:12]));
			chk(32'(fcs_append_o), 32'(!cf[13]));
			ev(6);
			for (int k = 1; k < 5; k++)
				if (r[k])
					ev(k);
			ev(0);
			st = 16'(r[4:1]) | (i == 2 ? 16'h0180 : 16'h0000);
			fin();
			chk(32'(mlast), 32'(st));
			rdr(8'h0C);
			chk(rd, 32'({cf[15:12], 1'b0, st[10:0]}));
		end
		rdr(8'h10);
		chk(rd, 32'h3);
		chk(32'(irq_o), 32'h0);
		wr(8'h14, 32'h2);
		repeat (2) @(posedge ref_clk_i);
		chk(32'(irq_o), 32'h1);
		wr(8'h10, 32'h3);
		wr(8'h14, 32'h0);
		rdr(8'h10);
		chk(rd, 32'h0);
		send(16'h0000);
		deferring_i <= 1;
		for (n = 0; n < 200 && !tx_abort_o; n++)
			@(posedge ref_clk_i);
		deferring_i <= 0;
		tmo(n);
		fin();
		chk(32'(mlast & 16'h07FF), 32'h0600);
		rdr(8'h0C);
		chk(rd, 32'h0400);
		send(16'h0000);
		repeat (16) ev(5);
		fin();
		chk(32'(mlast & 16'h07FF), 32'h0040);
		send(16'h1000);
		deferring_i <= 1;
		repeat (60) @(posedge ref_clk_i);
		deferring_i <= 0;
		ev(0);
		fin();
		chk(32'(mlast & 16'h0400), 32'h0);
		// collision well past one slot after the preamble
		send(16'h4000);
		ev(7);
		repeat (25) @(posedge ref_clk_i);
		ev(5);
		ev(0);
		fin();
		chk(32'(mlast & 16'h07FF), 32'h0020);
		rdr(8'h0C);
		chk(rd, 32'h4000);
		// fetch and start while frozen must leave no trace
		ce_i <= 0;
		mword <= 16'hB000;
		msel <= 1;
		desc_fetch_i <= 1;
		tx_start_i <= 1;
		@(posedge ref_clk_i);
		ce_i <= 1;
		msel <= 0;
		desc_fetch_i <= 0;
		tx_start_i <= 0;
		@(posedge ref_clk_i);
		chk(32'(packet_irq_set_o), 32'h0);
		rdr(8'h0C);
		chk(rd, 32'h4000);
		rdr(8'h10);
		chk(32'(rd[0]), 32'h0);
		// hardware reset at the end, with the block idle
		rst_n_i <= 0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1;
		rdr(8'h0C);
		chk(rd, 32'h0102);
		end_of_test();
	end
endmodule // tb_transmit_control_status_register
